// [shared/iblb_pkg.sv]
package iblb_pkg;
   // bus field widths
   localparam int GRP_W  = 3;
   localparam int ADR_W  = 3;
   localparam int DAT_W  = 4;
   localparam int RDB_W  = 8;
   // groups decoded by this block
   localparam logic [2:0] GRP_SEL = 3'h7;
   localparam logic [2:0] GRP_LO  = 3'h6;
   localparam logic [2:0] GRP_HI  = 3'h5;
   // group seven addresses, and the group-six parity address
   localparam logic [2:0] ADR_CLR_I   = 3'h0;
   localparam logic [2:0] ADR_PAIR    = 3'h1;
   localparam logic [2:0] ADR_CPL_A   = 3'h2;
   localparam logic [2:0] ADR_CPL_B   = 3'h3;
   localparam logic [2:0] ADR_READ    = 3'h4;
   localparam logic [2:0] ADR_CPL_C   = 3'h5;
   localparam logic [2:0] ADR_CLR_V   = 3'h6;
   localparam logic [2:0] ADR_CMD     = 3'h7;
   localparam logic [2:0] ADR_PARITY  = 3'h7;
   // data codes on the clear and command addresses
   localparam logic [3:0] DAT_ZERO    = 4'h0;
   localparam logic [3:0] CMD_CLR_V   = 4'h1;
   localparam logic [3:0] CMD_CLR_I   = 4'h2;
   // data and readback bit positions
   localparam int PAR_BIT_A = 0;
   localparam int PAR_BIT_B = 2;
   localparam int RDB_FLAG_BIT = 4;
   // readback source selection
   typedef enum logic [1:0] {
      IBLB_RD_PARITY  = 2'b00,
      IBLB_RD_CURRENT = 2'b01,
      IBLB_RD_VOLTAGE = 2'b10
   } iblb_rdsrc_t;
   // reset values
   localparam logic [7:0] STROBE_IDLE = 8'hFF;
   localparam logic [3:0] LATCH_RST   = 4'h0;
   localparam logic [7:0] BANK_RST    = 8'h00;
endpackage : iblb_pkg

// [logic/iblb_trigger.sv]
`timescale 1ns/1ps
// self-biasing counter-input trigger with output selector
module iblb_trigger
   import iblb_pkg::*;
(
   input  wire logic core_clk_in,
   input  wire logic rst_in,
   input  wire logic upper_trip_in,
   input  wire logic lower_trip_in,
   input  wire logic osc_square_in,
   input  wire logic select_osc_in,
   output logic      trig_state_out,
   output logic      counter_drive_out
);
   logic up_s1, up_s2, lo_s1, lo_s2, osc_s1, osc_s2;

   // two-stage synchronisers for the analog comparator and oscillator inputs
   always_ff @(posedge core_clk_in) begin
      up_s1  <= upper_trip_in;
      up_s2  <= up_s1;
      lo_s1  <= lower_trip_in;
      lo_s2  <= lo_s1;
      osc_s1 <= osc_square_in;
      osc_s2 <= osc_s1;
   end

   // set-reset state holds when both comparators release
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         trig_state_out <= 1'b0;
      end else if (up_s2) begin
         trig_state_out <= 1'b1;
      end else if (lo_s2) begin
         trig_state_out <= 1'b0;
      end
   end

   // output switch to the frequency counter
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         counter_drive_out <= 1'b0;
      end else begin
         counter_drive_out <= select_osc_in ? osc_s2 : trig_state_out;
      end
   end
endmodule : iblb_trigger

// [logic/iblb_top.sv]
`timescale 1ns/1ps
module iblb_top
   import iblb_pkg::*;
(
   input  wire logic             core_clk_in,
   input  wire logic             rst_in,
   input  wire logic             wr_in,
   input  wire logic [GRP_W-1:0] grp_in,
   input  wire logic [ADR_W-1:0] adr_in,
   input  wire logic [DAT_W-1:0] dat_in,
   input  wire logic             current_overload_sense_in,
   input  wire logic             voltage_overload_sense_in,
   input  wire logic             upper_trip_in,
   input  wire logic             lower_trip_in,
   input  wire logic             osc_square_in,
   output logic [7:0]            strobe_n_out,
   output logic [3:0]            cpl_a_out,
   output logic [3:0]            cpl_a_n_out,
   output logic [3:0]            cpl_b_out,
   output logic [3:0]            cpl_b_n_out,
   output logic [3:0]            cpl_c_out,
   output logic [3:0]            cpl_c_n_out,
   output logic [1:0]            pair_out,
   output logic                  current_flag_n_out,
   output logic                  current_flag_out,
   output logic                  voltage_flag_n_out,
   output logic                  voltage_flag_out,
   output logic [7:0]            bank_lo_out [4],
   output logic [7:0]            bank_hi_out [4],
   output logic                  parity_out,
   output logic [RDB_W-1:0]      readback_out,
   output logic                  pen_lift_out,
   output logic [7:0]            plot_x_out,
   output logic [7:0]            plot_y_out,
   output logic                  trig_state_out,
   output logic                  counter_drive_out
);
   // sense pin synchroniser stages
   logic             ci_s1, ci_s2;
   logic             cv_s1, cv_s2;
   // writes qualified by group
   logic             wr7, wr6, wr5;
   // decoded clear and readback-select commands
   logic             clr_i_zero, clr_i_cmd, clr_v_zero, clr_v_cmd;
   logic             sel_parity, sel_current, sel_voltage;
   // counter-input selector from the address-one latch
   logic             select_osc;
   // overload flags, high while set
   logic             current_flag, voltage_flag;
   // readback source and the word it builds
   iblb_rdsrc_t      rd_src;
   logic [RDB_W-1:0] next_readback;

   // true when a write hits the given group and address
   function automatic logic hit(input logic [2:0] g, input logic [2:0] a,
                                input logic [2:0] gi, input logic [2:0] ai);
      hit = (g == gi) && (a == ai);
   endfunction : hit

   // write strobe qualified by one group code
   function automatic logic grp_wr(input logic w, input logic [2:0] g,
                                   input logic [2:0] gi);
      grp_wr = w && (g == gi);
   endfunction : grp_wr

   // low pattern with only the addressed strobe line pulled down
   function automatic logic [7:0] strobe_code(input logic [2:0] a);
      case (a)
         3'h0:    strobe_code = 8'hFE;
         3'h1:    strobe_code = 8'hFD;
         3'h2:    strobe_code = 8'hFB;
         3'h3:    strobe_code = 8'hF7;
         3'h4:    strobe_code = 8'hEF;
         3'h5:    strobe_code = 8'hDF;
         3'h6:    strobe_code = 8'hBF;
         3'h7:    strobe_code = 8'h7F;
         default: strobe_code = STROBE_IDLE;
      endcase
   endfunction : strobe_code

   // parity taken over the two checked data bits
   function automatic logic parity_of(input logic [3:0] d);
      parity_of = d[PAR_BIT_A] ^ d[PAR_BIT_B];
   endfunction : parity_of

   // write qualified by group
   assign wr7 = grp_wr(wr_in, grp_in, GRP_SEL);
   assign wr6 = grp_wr(wr_in, grp_in, GRP_LO);
   assign wr5 = grp_wr(wr_in, grp_in, GRP_HI);

   // clear and readback-select commands
   assign clr_i_zero  = wr7 && adr_in == ADR_CLR_I && dat_in == DAT_ZERO;
   assign clr_i_cmd   = wr7 && adr_in == ADR_CMD && dat_in == CMD_CLR_I;
   assign clr_v_zero  = wr7 && adr_in == ADR_CLR_V && dat_in == DAT_ZERO;
   assign clr_v_cmd   = wr7 && adr_in == ADR_CMD && dat_in == CMD_CLR_V;
   assign sel_parity  = wr6 && adr_in == ADR_PARITY;
   assign sel_current = wr_in && hit(GRP_SEL, ADR_CLR_I, grp_in, adr_in);
   assign sel_voltage = wr_in && hit(GRP_SEL, ADR_CLR_V, grp_in, adr_in);

   // synchronise the current overload sense pin
   always_ff @(posedge core_clk_in) begin
      ci_s1 <= current_overload_sense_in;
      ci_s2 <= ci_s1;
   end

   // synchronise the voltage overload sense pin
   always_ff @(posedge core_clk_in) begin
      cv_s1 <= voltage_overload_sense_in;
      cv_s2 <= cv_s1;
   end

   // select decoder: one low strobe for each group-seven write
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         strobe_n_out <= STROBE_IDLE;
      end else if (wr7) begin
         strobe_n_out <= strobe_code(adr_in);
      end else begin
         strobe_n_out <= STROBE_IDLE;
      end
   end

   // first complementary latch, group seven address two
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         cpl_a_out <= LATCH_RST;
      end else if (wr7 && adr_in == ADR_CPL_A) begin
         cpl_a_out <= dat_in;
      end
   end

   // second complementary latch, group seven address three
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         cpl_b_out <= LATCH_RST;
      end else if (wr7 && adr_in == ADR_CPL_B) begin
         cpl_b_out <= dat_in;
      end
   end

   // third complementary latch, group seven address five
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         cpl_c_out <= LATCH_RST;
      end else if (wr7 && adr_in == ADR_CPL_C) begin
         cpl_c_out <= dat_in;
      end
   end

   // complement outputs are the inverse of each latch
   assign cpl_a_n_out = ~cpl_a_out;
   assign cpl_b_n_out = ~cpl_b_out;
   assign cpl_c_n_out = ~cpl_c_out;

   // address-one latch, each output follows its own one of the two low data bits
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         pair_out <= 2'h0;
      end else if (wr7 && adr_in == ADR_PAIR) begin
         pair_out <= {dat_in[1], dat_in[0]};
      end
   end

   // current overload flag: set wins over a clear in the same cycle
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         current_flag <= 1'b0;
      end else if (!ci_s2) begin
         current_flag <= 1'b1;
      end else if (clr_i_zero) begin
         current_flag <= 1'b0;
      end else if (clr_i_cmd) begin
         current_flag <= 1'b0;
      end
   end

   // true output low while set, complement high
   assign current_flag_out   = ~current_flag;
   assign current_flag_n_out = current_flag;

   // voltage overload flag: set wins over a clear in the same cycle
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         voltage_flag <= 1'b0;
      end else if (!cv_s2) begin
         voltage_flag <= 1'b1;
      end else if (clr_v_zero) begin
         voltage_flag <= 1'b0;
      end else if (clr_v_cmd) begin
         voltage_flag <= 1'b0;
      end
   end

   // true output low while set, complement high
   assign voltage_flag_out   = ~voltage_flag;
   assign voltage_flag_n_out = voltage_flag;

   // group six bank: sub-address picks the bit in each chip
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         for (int c = 0; c < 4; c++) begin
            bank_lo_out[c] <= BANK_RST;
         end
      end else if (wr6) begin
         for (int c = 0; c < 4; c++) begin
            bank_lo_out[c][adr_in] <= dat_in[c];
         end
      end
   end

   // group five bank: sub-address picks the bit in each chip
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         for (int c = 0; c < 4; c++) begin
            bank_hi_out[c] <= BANK_RST;
         end
      end else if (wr5) begin
         for (int c = 0; c < 4; c++) begin
            bank_hi_out[c][adr_in] <= dat_in[c];
         end
      end
   end

   // parity of the last group-six address-seven write
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         parity_out <= 1'b0;
      end else if (sel_parity) begin
         parity_out <= parity_of(dat_in);
      end
   end

   // readback source follows the last selecting write
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         rd_src <= IBLB_RD_PARITY;
      end else if (sel_parity) begin
         rd_src <= IBLB_RD_PARITY;
      end else if (sel_current) begin
         rd_src <= IBLB_RD_CURRENT;
      end else if (sel_voltage) begin
         rd_src <= IBLB_RD_VOLTAGE;
      end
   end

   // readback word with the selected state on bit four
   always_comb begin
      next_readback = '0;
      case (rd_src)
         IBLB_RD_PARITY:  next_readback[RDB_FLAG_BIT] = parity_out;
         IBLB_RD_CURRENT: next_readback[RDB_FLAG_BIT] = ~ci_s2;
         IBLB_RD_VOLTAGE: next_readback[RDB_FLAG_BIT] = ~cv_s2;
         default:         next_readback[RDB_FLAG_BIT] = 1'b0;
      endcase
   end

   // readback register presented to the controller
   always_ff @(posedge core_clk_in) begin
      if (rst_in) begin
         readback_out <= '0;
      end else begin
         readback_out <= next_readback;
      end
   end

   // pen lift is the upper bit of the address-one latch, high lifts
   assign pen_lift_out = pair_out[1];

   // plot converter codes come from chip zero of each bank
   assign plot_x_out   = bank_hi_out[0];
   assign plot_y_out   = bank_lo_out[0];

   // counter selector is the lower bit of the address-one latch
   assign select_osc   = pair_out[0];

   // trigger and counter-input selector; selector bit from pair latch
   iblb_trigger u_trig (
      .core_clk_in       (core_clk_in),
      .rst_in            (rst_in),
      .upper_trip_in     (upper_trip_in),
      .lower_trip_in     (lower_trip_in),
      .osc_square_in     (osc_square_in),
      .select_osc_in     (select_osc),
      .trig_state_out    (trig_state_out),
      .counter_drive_out (counter_drive_out)
   );
endmodule : iblb_top

// [verification/iblb_sva.sv]
`timescale 1ns/1ps
// port checker for the latch block
module iblb_sva
   import iblb_pkg::*;
(
   input  wire logic             core_clk_in,
   input  wire logic             rst_in,
   input  wire logic             wr_in,
   input  wire logic [GRP_W-1:0] grp_in,
   input  wire logic [ADR_W-1:0] adr_in,
   input  wire logic [DAT_W-1:0] dat_in,
   input  wire logic             current_overload_sense_in,
   input  wire logic             upper_trip_in,
   input  wire logic             lower_trip_in,
   input  wire logic [7:0]       strobe_n_out,
   input  wire logic [3:0]       cpl_a_out,
   input  wire logic [3:0]       cpl_a_n_out,
   input  wire logic [1:0]       pair_out,
   input  wire logic             current_flag_out,
   input  wire logic             parity_out,
   input  wire logic             trig_state_out
);
   default clocking cb @(posedge core_clk_in); endclocking
   default disable iff (rst_in);
   logic g7w;
   // group seven write qualifier
   assign g7w = wr_in && grp_in == GRP_SEL;
   // sense history and clear command steps
   sequence i_low_s; !current_overload_sense_in [*4]; endsequence
   sequence i_quiet_s; current_overload_sense_in [*4]; endsequence
   sequence i_clr_s;
      g7w && (adr_in == ADR_CLR_I && dat_in == DAT_ZERO ||
              adr_in == ADR_CMD && dat_in == CMD_CLR_I);
   endsequence
   one_strobe_a:
      assert property (g7w |=> strobe_n_out == ~(8'h01 << $past(adr_in)))
      else $error("strobe pattern wrong");
   cpl_follow_a:
      assert property (g7w && adr_in == ADR_CPL_A |=> cpl_a_out ==
         $past(dat_in) && cpl_a_n_out == ~cpl_a_out)
      else $error("complement latch wrong");
   cpl_hold_a:
      assert property (!(g7w && adr_in == ADR_CPL_A) |=> $stable(cpl_a_out))
      else $error("latch changed without write");
   pair_latch_a:
      assert property (g7w && adr_in == ADR_PAIR |=>
         pair_out == $past(dat_in[1:0]))
      else $error("pair latch wrong");
   cur_set_a:
      assert property (i_low_s |=> !current_flag_out)
      else $error("current flag not set");
   cur_clear_a:
      assert property (i_quiet_s ##0 i_clr_s |=> current_flag_out)
      else $error("current flag not cleared");
   parity_gen_a:
      assert property (wr_in && grp_in == GRP_LO && adr_in == ADR_PARITY
         |=> parity_out == ($past(dat_in[0]) ^ $past(dat_in[2])))
      else $error("parity wrong");
   trig_set_a:
      assert property (upper_trip_in [*4] |=> trig_state_out)
      else $error("trigger not set");
   trig_reset_a:
      assert property ((lower_trip_in && !upper_trip_in) [*4]
         |=> !trig_state_out)
      else $error("trigger not reset");
endmodule : iblb_sva

bind iblb_top iblb_sva i_iblb_sva (.core_clk_in, .rst_in, .wr_in,
   .grp_in, .adr_in, .dat_in, .current_overload_sense_in, .upper_trip_in,
   .lower_trip_in, .strobe_n_out, .cpl_a_out, .cpl_a_n_out, .pair_out,
   .current_flag_out, .parity_out, .trig_state_out);

// [verification/iblb_ctrl_model.sv]
`timescale 1ns/1ps
// controller side: one-cycle write pulses on the instrument bus
module iblb_ctrl_model
   import iblb_pkg::*;
(
   input  wire logic             core_clk_in,
   output logic                  wr_out,
   output logic [GRP_W-1:0]      grp_out,
   output logic [ADR_W-1:0]      adr_out,
   output logic [DAT_W-1:0]      dat_out
);
   // bus idle at time zero
   initial begin
      wr_out = 1'b0;
      {grp_out, adr_out, dat_out} = '0;
   end
   // fields launched off the falling edge, released bus shows inverse
   task automatic w(input logic [2:0] g, a, input logic [3:0] d);
      @(negedge core_clk_in);
      {grp_out, adr_out, dat_out} = {g, a, d};
      wr_out = 1'b1;
      @(negedge core_clk_in);
      wr_out = 1'b0;
      {grp_out, adr_out, dat_out} = ~{g, a, d};
   endtask : w
endmodule : iblb_ctrl_model

// [verification/tb_top.sv]
`timescale 1ns/1ps
// bench: controller model writes, bench compares latch outputs
module tb_top;
   import iblb_pkg::*;
   logic core_clk_in = 1'b0;
   logic rst_in = 1'b1;
   logic wr_in;
   logic [2:0] grp_in, adr_in;
   logic [3:0] dat_in, cpl_a_out, cpl_a_n_out, cpl_b_out, cpl_b_n_out;
   logic [3:0] cpl_c_out, cpl_c_n_out;
   logic current_overload_sense_in = 1'b1, voltage_overload_sense_in = 1'b1;
   logic upper_trip_in = 1'b0, lower_trip_in = 1'b0, osc_square_in = 1'b0;
   logic [7:0] strobe_n_out, readback_out, plot_x_out, plot_y_out;
   logic [7:0] bank_lo_out [4], bank_hi_out [4];
   logic [1:0] pair_out;
   logic current_flag_n_out, current_flag_out, voltage_flag_n_out;
   logic voltage_flag_out, parity_out, pen_lift_out;
   logic trig_state_out, counter_drive_out;
   logic [3:0] pd [4] = '{4'h0, 4'h1, 4'h4, 4'h5};
   int err_count = 0, total_checks = 0, cycles = 0;
   always #10 core_clk_in = ~core_clk_in;
   iblb_top i_iblb_top (.*);
   iblb_ctrl_model i_iblb_ctrl_model (.core_clk_in, .wr_out(wr_in),
      .grp_out(grp_in), .adr_out(adr_in), .dat_out(dat_in));
   task automatic chk(input string n, input logic [7:0] e, g);
      total_checks++;
      if (g !== e) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", n, e, g);
      end
   endtask : chk
   task automatic w(input logic [2:0] g, a, input logic [3:0] d);
      i_iblb_ctrl_model.w(g, a, d);
   endtask : w
   task automatic idle(input int n);
      repeat (n) @(negedge core_clk_in);
   endtask : idle
   function automatic logic [1:0] fl(input bit v);
      return v ? {voltage_flag_out, voltage_flag_n_out}
               : {current_flag_out, current_flag_n_out};
   endfunction : fl
   task automatic sense(input bit v, input logic s);
      @(negedge core_clk_in);
      if (v) voltage_overload_sense_in = s;
      else current_overload_sense_in = s;
      idle(4);
   endtask : sense
   // set, wrong clears, right clears, then live readback
   task automatic ovl(input bit v);
      sense(v, 1'b0);
      sense(v, 1'b1);
      chk("flag", 2'b01, fl(v));
      w(3'h7, v ? 3'h0 : 3'h6, 4'h0);
      w(3'h7, 3'h7, v ? 4'h2 : 4'h1);
      chk("flag", 2'b01, fl(v));
      w(3'h7, v ? 3'h6 : 3'h0, 4'h0);
      chk("flag", 2'b10, fl(v));
      sense(v, 1'b0);
      sense(v, 1'b1);
      w(3'h7, 3'h7, v ? 4'h1 : 4'h2);
      chk("flag", 2'b10, fl(v));
      w(3'h7, v ? 3'h6 : 3'h0, 4'h0);
      sense(v, 1'b0);
      chk("readback", 8'h10, readback_out);
      sense(v, 1'b1);
      chk("readback", 8'h00, readback_out);
   endtask : ovl
   task automatic end_of_test;
      if (err_count == 0 && total_checks > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask : end_of_test
   // cycle ceiling cuts a hang short
   always @(posedge core_clk_in) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         err_count++;
         end_of_test();
      end
   end
   // main sequence
   initial begin
      idle(8);
      rst_in = 1'b0;
      for (int a = 0; a < 8; a++) begin
         w(3'h7, 3'(a), 4'h0);
         chk("strobe", ~(8'h01 << a), strobe_n_out);
         idle(1);
         chk("strobe", 8'hFF, strobe_n_out);
      end
      w(3'h4, 3'h2, 4'hF);
      chk("cpl", 8'h0F, {cpl_a_out, cpl_a_n_out});
      for (int i = 0; i < 2; i++) begin
         w(3'h7, 3'h2, i ? 4'h0 : 4'hF);
         w(3'h7, 3'h3, i ? 4'h0 : 4'hF);
         w(3'h7, 3'h5, i ? 4'h0 : 4'hF);
         chk("cpl", i ? 8'h0F : 8'hF0, {cpl_a_out, cpl_a_n_out});
         chk("cpl", i ? 8'h0F : 8'hF0, {cpl_b_out, cpl_b_n_out});
         chk("cpl", i ? 8'h0F : 8'hF0, {cpl_c_out, cpl_c_n_out});
      end
      w(3'h7, 3'h1, 4'h0);
      chk("pair", 8'h00, {pen_lift_out, pair_out});
      upper_trip_in = 1'b1;
      idle(4);
      chk("drive", 8'h03, {trig_state_out, counter_drive_out});
      upper_trip_in = 1'b0;
      idle(4);
      chk("trig", 8'h01, trig_state_out);
      lower_trip_in = 1'b1;
      idle(4);
      chk("drive", 8'h00, {trig_state_out, counter_drive_out});
      lower_trip_in = 1'b0;
      upper_trip_in = 1'b1;
      w(3'h7, 3'h1, 4'hF);
      chk("pair", 8'h07, {pen_lift_out, pair_out});
      chk("drive", 8'h00, counter_drive_out);
      osc_square_in = 1'b1;
      idle(4);
      chk("drive", 8'h01, counter_drive_out);
      for (int g = 5; g < 7; g++)
         for (int i = 0; i < 2; i++)
            for (int a = 0; a < 8; a++) begin
               w(3'(g), 3'(a), i ? 4'h0 : 4'hF);
               for (int c = 0; c < 4; c++)
                  chk("bank", i ? 8'hFE << a : 8'hFF >> (7 - a),
                      g == 6 ? bank_lo_out[c] : bank_hi_out[c]);
               chk("plot", i ? 8'hFE << a : 8'hFF >> (7 - a),
                   g == 6 ? plot_y_out : plot_x_out);
            end
      for (int i = 0; i < 4; i++) begin
         w(3'h6, 3'h7, pd[i]);
         chk("parity", pd[i][0] ^ pd[i][2], parity_out);
         w(3'h7, 3'h4, 4'h0);
         idle(2);
         chk("readback", {3'h0, pd[i][0] ^ pd[i][2], 4'h0},
             readback_out);
      end
      ovl(1'b0);
      ovl(1'b1);
      end_of_test();
   end
endmodule : tb_top
